// file: include/wdt_pkg.sv
// Package: constants, types and helpers for the watchdog and reset guard
package wdt_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS        = 4;
	localparam int SLOW_OSC_KHZ         = 32;
	localparam int KEY_FAULT_DELAY_NS   = 1000;
	localparam int KEY_FAULT_DELAY_CYC  = (KEY_FAULT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam int          ADDR_W         = 8;
	localparam logic [7:0]  OFS_CONTROL    = 8'h00;
	localparam logic [7:0]  OFS_CAUSE      = 8'h04;
	localparam logic [7:0]  OFS_GUARD      = 8'h08;
	localparam logic [7:0]  OFS_STATE      = 8'h0c;
	localparam logic [7:0]  OFS_INT_STATUS = 8'h10;
	localparam logic [7:0]  OFS_INT_ENABLE = 8'h14;
	localparam logic [7:0]  OFS_INT_CLEAR  = 8'h18;
	localparam logic [7:0]  OFS_COUNT      = 8'h1c;

	// ************************************************************
	// Reset values and key patterns
	// ************************************************************
	localparam logic [7:0]  CONTROL_RESET  = 8'h53;
	localparam logic [7:0]  GUARD_RESET    = 8'h55;
	localparam logic [7:0]  GUARD_KEY_A    = 8'h55;
	localparam logic [7:0]  GUARD_KEY_B    = 8'haa;
	localparam logic [4:0]  ARM_KEY_A      = 5'h15;
	localparam logic [4:0]  ARM_KEY_B      = 5'h0a;
	localparam logic [3:0]  CAUSE_RESET    = 4'h0;
	localparam logic [3:0]  INT_EN_RESET   = 4'h0;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CAUSE_WDT_KEY  = 0;
	localparam int CAUSE_VOLT_KEY = 1;
	localparam int CAUSE_UNDERV   = 2;
	localparam int CAUSE_GUARD    = 3;
	localparam int EV_TIMEOUT_RUN = 0;
	localparam int EV_TIMEOUT_PD  = 1;
	localparam int EV_WDT_KEY     = 2;
	localparam int EV_GUARD_KEY   = 3;
	localparam int ST_EXPIRY      = 0;
	localparam int ST_POWER_DOWN  = 1;

	localparam int CNT_W = 19;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed
	{
		logic [4:0] arm_key;
		logic [2:0] period_select;
	} watchdog_control_s;

	typedef enum logic [1:0]
	{
		FT_IDLE = 2'b00,
		FT_WAIT = 2'b01,
		FT_FIRE = 2'b10
	} fault_state_e;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic arm_key_ok(input logic [4:0] k);
		arm_key_ok = (k == ARM_KEY_A) || (k == ARM_KEY_B);
	endfunction

	function automatic logic guard_key_ok(input logic [7:0] k);
		guard_key_ok = (k == GUARD_KEY_A) || (k == GUARD_KEY_B);
	endfunction

	function automatic logic [CNT_W-1:0] period_limit(input logic [2:0] sel);
		case (sel)
			3'h0:    period_limit = 19'h00100;
			3'h1:    period_limit = 19'h00400;
			3'h2:    period_limit = 19'h01000;
			3'h3:    period_limit = 19'h04000;
			3'h4:    period_limit = 19'h08000;
			3'h5:    period_limit = 19'h10000;
			3'h6:    period_limit = 19'h20000;
			default: period_limit = 19'h40000;
		endcase
	endfunction

endpackage

// file: rtl/osc_tick_sync.sv
// Synchroniser and rising-edge tick for the slow oscillator pin
`timescale 1ns/10ps
module osc_tick_sync
	import wdt_pkg::*;
(
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic osc_pin,
	output logic      tick
);

	logic meta;
	logic sync;
	logic sync_d;

	// Two stages, then an edge detector on the second
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta   <= 1'b0;
			sync   <= 1'b0;
			sync_d <= 1'b0;
			tick   <= 1'b0;
		end
		else
		begin
			meta   <= osc_pin;
			sync   <= meta;
			sync_d <= sync;
			tick   <= sync & ~sync_d;
		end
	end

endmodule // osc_tick_sync

// file: rtl/key_fault_timer.sv
// Delay from a key fault to the reset it causes
`timescale 1ns/10ps
module key_fault_timer
	import wdt_pkg::*;
#(
	parameter int DELAY_CYC = KEY_FAULT_DELAY_CYC
)
(
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic fault,
	output logic      fire
);

	localparam int CW = $clog2(DELAY_CYC + 1);

	fault_state_e    state;
	fault_state_e    next_state;
	logic [CW-1:0]   cnt;
	logic            done;

	assign done = (cnt == CW'(DELAY_CYC - 1));
	assign fire = (state == FT_FIRE);

	// Once started the delay runs out even if the key is repaired
	always_comb
	begin
		case (state)
			FT_IDLE: next_state = fault ? FT_WAIT : FT_IDLE;
			FT_WAIT: next_state = done ? FT_FIRE : FT_WAIT;
			FT_FIRE: next_state = FT_IDLE;
			default: next_state = FT_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= FT_IDLE;
			cnt   <= '0;
		end
		else
		begin
			state <= next_state;
			cnt   <= (state == FT_WAIT) ? cnt + CW'(1) : '0;
		end
	end

endmodule // key_fault_timer

// file: rtl/wdt_top.sv
// Watchdog timer, reset guard key and reset-cause flags behind APB
//
// Function
// (RULE_01) Counter advances on slow oscillator ticks; time-out is a power-of-two count.
// (RULE_02) Select codes 0 to 6 give 2^8,2^10,2^12,2^14,2^15,2^16,2^17 periods.
// (RULE_03) Select code 7 gives 2^18 periods, the longest time-out.
// (RULE_04) Arm key 10101 or 01010 keeps watchdog running; no code stops it.
// (RULE_05) Any other arm key gives full reset after delay and sets its flag.
// (RULE_06) Control register powers up as 0x53: key 01010, select 011.
// (RULE_07) Arm-key cause flag in bit 0 set by fault, cleared only by writing zero.
// (RULE_08) Cause bits 7 to 4 read zero; guard, line and arm flags power up zero.
// (RULE_09) Counter overflow in normal operation gives a full reset.
// (RULE_10) Time-out sets expiry flag; in power-down only PC and SP reset.
// (RULE_11) Counter cleared by illegal key write, clear instruction, and halt instruction.
// (RULE_12) One clear instruction alone clears the counter.
// (RULE_13) Guard key 0x55 or 0xaa does nothing; else full reset after delay.
// (RULE_14) Guard key register powers up as 0x55.
// (RULE_15) Power-on reset loads the program counter with zero.
// (RULE_16) Power-on reset presets all port data and direction registers to ones.
// (RULE_17) Guard-key cause flag in bit 3 set by guard fault, cleared only by software.
// (RULE_18) After any clear the count restarts at zero and expires after full period.
`timescale 1ns/10ps
module wdt_top
	import wdt_pkg::*;
#(
	parameter int DELAY_CYC = KEY_FAULT_DELAY_CYC
)
(
	input  wire logic              CLK_SYS,
	input  wire logic              ARST_N,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [31:0]       PWDATA,
	input  wire logic [3:0]        PSTRB,
	output logic                   PREADY,
	output logic [31:0]            PRDATA,
	output logic                   PSLVERR,
	input  wire logic              SLOW_OSC,
	input  wire logic              CLEAR_WATCHDOG_INSTR,
	input  wire logic              HALT_INSTR,
	input  wire logic              POWER_DOWN,
	input  wire logic              VOLTAGE_KEY_FAULT,
	input  wire logic              UNDERVOLTAGE_EVENT,
	output logic                   FULL_RESET,
	output logic                   PC_SP_RESET,
	output logic                   PC_ZERO_LOAD,
	output logic                   PORT_PRESET,
	output logic                   WATCHDOG_EXPIRY_FLAG,
	output logic                   IRQ
);

	// ************************************************************
	// Storage
	// ************************************************************
	watchdog_control_s  watchdog_control;
	logic [7:0]         reset_guard_key;
	logic [3:0]         reset_cause_flags;
	logic [3:0]         int_status;
	logic [3:0]         int_enable;
	logic [CNT_W-1:0]   count;
	logic               osc_tick;
	logic [1:0]         fault;
	logic [1:0]         fire;

	// ************************************************************
	// APB decode
	// ************************************************************
	logic               access;
	logic               wr;
	logic               rd;
	logic               lane0;
	logic               hit_control;
	logic               hit_cause;
	logic               hit_guard;
	logic               hit_state;
	logic               hit_int_status;
	logic               hit_int_enable;
	logic               hit_int_clear;
	logic               hit_count;
	logic               mapped;
	logic [31:0]        next_prdata;

	assign access         = PSEL & PENABLE & ~PREADY;
	assign wr             = access & PWRITE;
	assign rd             = access & ~PWRITE;
	assign lane0          = PSTRB[0];
	assign hit_control    = (PADDR == OFS_CONTROL);
	assign hit_cause      = (PADDR == OFS_CAUSE);
	assign hit_guard      = (PADDR == OFS_GUARD);
	assign hit_state      = (PADDR == OFS_STATE);
	assign hit_int_status = (PADDR == OFS_INT_STATUS);
	assign hit_int_enable = (PADDR == OFS_INT_ENABLE);
	assign hit_int_clear  = (PADDR == OFS_INT_CLEAR);
	assign hit_count      = (PADDR == OFS_COUNT);
	assign mapped         = hit_control | hit_cause | hit_guard | hit_state
	                      | hit_int_status | hit_int_enable | hit_int_clear | hit_count;

	logic               wr_control;
	logic               wr_cause;
	logic               wr_guard;
	logic               wr_int_enable;
	logic               wr_int_clear;

	assign wr_control    = wr & hit_control & lane0;
	assign wr_cause      = wr & hit_cause & lane0;
	assign wr_guard      = wr & hit_guard & lane0;
	assign wr_int_enable = wr & hit_int_enable & lane0;
	assign wr_int_clear  = wr & hit_int_clear & lane0;

	// Upper bits of narrow registers read as zero
	assign next_prdata =
		hit_control    ? {24'h0, watchdog_control} :
		hit_cause      ? {28'h0, reset_cause_flags} :  // RULE_08
		hit_guard      ? {24'h0, reset_guard_key} :
		hit_state      ? {30'h0, POWER_DOWN, WATCHDOG_EXPIRY_FLAG} :
		hit_int_status ? {28'h0, int_status} :
		hit_int_enable ? {28'h0, int_enable} :
		hit_count      ? {13'h0, count} :
		32'h0;

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY  <= access;
			PRDATA  <= rd ? next_prdata : 32'h0;
			PSLVERR <= access & ~mapped;
		end
	end

	// ************************************************************
	// Slow oscillator tick
	// ************************************************************
	osc_tick_sync u_tick
	(
		.clk     (CLK_SYS),
		.arst_n  (ARST_N),
		.osc_pin (SLOW_OSC),
		.tick    (osc_tick)
	);

	// ************************************************************
	// Key fault delay
	// ************************************************************
	assign fault[0] = ~arm_key_ok(watchdog_control.arm_key);  // RULE_05
	assign fault[1] = ~guard_key_ok(reset_guard_key);         // RULE_13

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_fault
			key_fault_timer #(.DELAY_CYC(DELAY_CYC)) u_delay
			(
				.clk    (CLK_SYS),
				.arst_n (ARST_N),
				.fault  (fault[gi]),
				.fire   (fire[gi])
			);
		end
	endgenerate

	// ************************************************************
	// Watchdog counter
	// ************************************************************
	logic [CNT_W-1:0]   limit;
	logic [CNT_W-1:0]   count_inc;
	logic               bad_key_write;
	logic               expire;
	logic               expire_run;
	logic               expire_pd;
	logic               full_reset_now;
	logic               clear_count;

	assign limit          = period_limit(watchdog_control.period_select);  // RULE_02 RULE_03
	assign count_inc      = count + CNT_W'(1);
	assign bad_key_write  = wr_control & ~arm_key_ok(PWDATA[7:3]);
	assign expire         = osc_tick & (count_inc >= limit);  // RULE_01 RULE_18
	assign expire_run     = expire & ~POWER_DOWN;
	assign expire_pd      = expire & POWER_DOWN;
	assign full_reset_now = expire_run | fire[0] | fire[1];  // RULE_09 RULE_05 RULE_13
	assign clear_count    = bad_key_write | CLEAR_WATCHDOG_INSTR | HALT_INSTR;  // RULE_11 RULE_12

	// Counting never stops: the arm key only faults, never disables
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
			count <= '0;
		else if (clear_count | full_reset_now | expire)
			count <= '0;  // RULE_18
		else if (osc_tick)
			count <= count_inc;  // RULE_04
	end

	// ************************************************************
	// Control and guard key registers
	// ************************************************************
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			watchdog_control <= CONTROL_RESET;  // RULE_06
			reset_guard_key  <= GUARD_RESET;    // RULE_14
		end
		else if (full_reset_now)
		begin
			watchdog_control <= CONTROL_RESET;
			reset_guard_key  <= GUARD_RESET;
		end
		else
		begin
			if (wr_control)
				watchdog_control <= PWDATA[7:0];
			if (wr_guard)
				reset_guard_key <= PWDATA[7:0];
		end
	end

	// ************************************************************
	// Reset cause flags
	// ************************************************************
	logic [3:0]         cause_set;
	logic [3:0]         cause_keep;

	assign cause_set[CAUSE_WDT_KEY]  = fire[0];             // RULE_07
	assign cause_set[CAUSE_VOLT_KEY] = VOLTAGE_KEY_FAULT;
	assign cause_set[CAUSE_UNDERV]   = UNDERVOLTAGE_EVENT;
	assign cause_set[CAUSE_GUARD]    = fire[1];             // RULE_17
	assign cause_keep = wr_cause ? (reset_cause_flags & PWDATA[3:0]) : reset_cause_flags;

	// Writing one never sets a flag; a set in the clearing cycle wins
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
			reset_cause_flags <= CAUSE_RESET;  // RULE_08
		else
			reset_cause_flags <= cause_keep | cause_set;  // RULE_07 RULE_17
	end

	// ************************************************************
	// Expiry flag and reset requests
	// ************************************************************
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			WATCHDOG_EXPIRY_FLAG <= 1'b0;
			FULL_RESET           <= 1'b0;
			PC_SP_RESET          <= 1'b0;
			PC_ZERO_LOAD         <= 1'b1;  // RULE_15
			PORT_PRESET          <= 1'b1;  // RULE_16
		end
		else
		begin
			if (expire)
				WATCHDOG_EXPIRY_FLAG <= 1'b1;  // RULE_10
			else if (HALT_INSTR | CLEAR_WATCHDOG_INSTR)
				WATCHDOG_EXPIRY_FLAG <= 1'b0;
			FULL_RESET   <= full_reset_now;  // RULE_09
			PC_SP_RESET  <= expire_pd;       // RULE_10
			PC_ZERO_LOAD <= full_reset_now | expire_pd;
			PORT_PRESET  <= full_reset_now;
		end
	end

	// ************************************************************
	// Interrupts
	// ************************************************************
	logic [3:0]         ev;
	logic [3:0]         int_keep;

	assign ev[EV_TIMEOUT_RUN] = expire_run;
	assign ev[EV_TIMEOUT_PD]  = expire_pd;
	assign ev[EV_WDT_KEY]     = fire[0];
	assign ev[EV_GUARD_KEY]   = fire[1];
	assign int_keep = wr_int_clear ? (int_status & ~PWDATA[3:0]) : int_status;

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			int_status <= 4'h0;
			int_enable <= INT_EN_RESET;
			IRQ        <= 1'b0;
		end
		else
		begin
			int_status <= int_keep | ev;
			if (wr_int_enable)
				int_enable <= PWDATA[3:0];
			IRQ <= |(int_status & int_enable);
		end
	end

endmodule // wdt_top

// file: testbench/wdt_chk.sv
// Checker: port-level assertions for the watchdog and reset guard
`timescale 1ns/10ps
module wdt_chk
	import wdt_pkg::*;
#(
	parameter int DELAY_CYC = KEY_FAULT_DELAY_CYC
)
(
	input logic        CLK_SYS,
	input logic        ARST_N,
	input logic        PSEL,
	input logic        PENABLE,
	input logic        PWRITE,
	input logic [7:0]  PADDR,
	input logic [31:0] PWDATA,
	input logic [3:0]  PSTRB,
	input logic        PREADY,
	input logic [31:0] PRDATA,
	input logic        PSLVERR,
	input logic        CLEAR_WATCHDOG_INSTR,
	input logic        HALT_INSTR,
	input logic        FULL_RESET,
	input logic        PC_SP_RESET,
	input logic        PC_ZERO_LOAD,
	input logic        PORT_PRESET,
	input logic        WATCHDOG_EXPIRY_FLAG
);
	localparam int FIRE_LO = DELAY_CYC;
	localparam int FIRE_HI = DELAY_CYC + 6;

	// Decoded write of an illegal key
	wire logic wr_take   = PSEL && PENABLE && !PREADY && PWRITE && PSTRB[0];
	wire logic arm_bad   = wr_take && PADDR == OFS_CONTROL && PWDATA[7:3] != ARM_KEY_A && PWDATA[7:3] != ARM_KEY_B;
	wire logic guard_bad = wr_take && PADDR == OFS_GUARD && PWDATA[7:0] != GUARD_KEY_A && PWDATA[7:0] != GUARD_KEY_B;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!ARST_N);

	sequence s_access;
		PSEL && PENABLE && !PREADY;
	endsequence
	sequence s_answer;
		PREADY ##1 !PREADY;
	endsequence
	sequence s_fire;
		##[FIRE_LO:FIRE_HI] FULL_RESET;
	endsequence

	a_apb_answer: assert property (s_access |=> s_answer)
		else $error("APB answer not one cycle after access");
	a_err_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
		else $error("Error response without ready or with data");
	a_rdata_quiet: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("Read data outside answer cycle");
	a_arm_fault: assert property (arm_bad |-> s_fire)
		else $error("Bad arm key gave no reset in time");
	a_guard_fault: assert property (guard_bad |-> s_fire)
		else $error("Bad guard key gave no reset in time");
	a_reset_pulse: assert property (FULL_RESET |=> !FULL_RESET)
		else $error("Full reset longer than one cycle");
	a_pd_reset: assert property (PC_SP_RESET |->
		WATCHDOG_EXPIRY_FLAG && PC_ZERO_LOAD && !PORT_PRESET && !FULL_RESET)
		else $error("Power-down time-out reset wrong");
	a_full_side: assert property (FULL_RESET |-> PC_ZERO_LOAD && PORT_PRESET)
		else $error("Full reset without counter and port preset");
	a_clear_flag: assert property ((CLEAR_WATCHDOG_INSTR || HALT_INSTR) |=>
		!WATCHDOG_EXPIRY_FLAG || FULL_RESET || PC_SP_RESET)
		else $error("Expiry flag not cleared");
	a_por_preset: assert property ($rose(ARST_N) |-> PC_ZERO_LOAD && PORT_PRESET)
		else $error("Power-on preset missing");
endmodule // wdt_chk

bind wdt_top wdt_chk #(.DELAY_CYC(DELAY_CYC)) u_chk (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY),
	.PRDATA(PRDATA), .PSLVERR(PSLVERR), .CLEAR_WATCHDOG_INSTR(CLEAR_WATCHDOG_INSTR), .HALT_INSTR(HALT_INSTR),
	.FULL_RESET(FULL_RESET), .PC_SP_RESET(PC_SP_RESET), .PC_ZERO_LOAD(PC_ZERO_LOAD), .PORT_PRESET(PORT_PRESET),
	.WATCHDOG_EXPIRY_FLAG(WATCHDOG_EXPIRY_FLAG));

// file: testbench/tb.sv
// Testbench: register, time-out and key-fault checks for the watchdog
`timescale 1ns/10ps
module tb
	import wdt_pkg::*;
;
	localparam int DLY = 4;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow_osc = 1'b0, power_down = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [3:0]  ev = 4'h0;
	logic        pready, pslverr, full_reset, pc_sp_reset, pc_zero_load, port_preset, expiry, irq, err;
	logic [31:0] prdata, rdv;
	int          err_count = 0, tests_run = 0, fr = 0, pc = 0, f0;

	wdt_top #(.DELAY_CYC(DLY)) dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata),
		.PSLVERR(pslverr), .SLOW_OSC(slow_osc), .CLEAR_WATCHDOG_INSTR(ev[0]), .HALT_INSTR(ev[1]),
		.POWER_DOWN(power_down), .VOLTAGE_KEY_FAULT(ev[2]), .UNDERVOLTAGE_EVENT(ev[3]), .FULL_RESET(full_reset),
		.PC_SP_RESET(pc_sp_reset), .PC_ZERO_LOAD(pc_zero_load), .PORT_PRESET(port_preset),
		.WATCHDOG_EXPIRY_FLAG(expiry), .IRQ(irq));

	initial
	begin
		forever #2 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		if (full_reset === 1'b1) fr <= fr + 1;
		if (pc_sp_reset === 1'b1) pc <= pc + 1;
	end

	task automatic summarize;
		$display("Compares %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			err_count++;
			summarize;
		end
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask

	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			slow_osc <= 1'b1;
			repeat (4) @(posedge clk_sys);
			slow_osc <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic pulse(input logic [3:0] m);
		@(posedge clk_sys);
		ev <= m;
		@(posedge clk_sys);
		ev <= 4'h0;
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic wait_reset(input int base);
		int n;
		n = 0;
		while (fr == base && n < DLY + 40)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (fr == base)
		begin
			err_count++;
			summarize;
		end
		repeat (3) @(posedge clk_sys);
	endtask

	// Clear, run pre ticks, clear again by m, then expect expiry after exactly ticks
	task automatic timeout(input logic [2:0] sel, input int pre, input int ticks, input logic [3:0] m);
		int base;
		wr(OFS_CONTROL, {24'h0, ARM_KEY_B, sel});
		pulse(4'h1);
		tick(pre);
		rd(OFS_COUNT, pre);
		pulse(m);
		base = power_down ? pc : fr;
		tick(ticks - 1);
		chk(power_down ? pc : fr, base);
		tick(1);
		chk(power_down ? pc : fr, base + 1);
		chk(expiry, 1'b1);
	endtask

	initial
	begin
		repeat (10) @(posedge clk_sys);
		chk(pc_zero_load, 1'b1);
		chk(port_preset, 1'b1);
		arst_n <= 1'b1;
		rd(OFS_CONTROL, 32'h53);
		rd(OFS_GUARD, 32'h55);
		rd(OFS_CAUSE, 32'h0);
		for (int s = 0; s < 8; s++)
		begin
			wr(OFS_CONTROL, {24'h0, ARM_KEY_A, s[2:0]});
			rd(OFS_CONTROL, {24'h0, ARM_KEY_A, s[2:0]});
		end
		apb(1'b0, 8'h20, 32'h0);
		chk({err, rdv[30:0]}, 32'h80000000);
		pulse(4'hc);
		wr(OFS_CAUSE, 32'hf4);
		rd(OFS_CAUSE, 32'h4);
		wr(OFS_CAUSE, 32'h0);
		timeout(3'h0, 0, 256, 4'h1);
		timeout(3'h1, 0, 1024, 4'h1);
		timeout(3'h0, 200, 256, 4'h1);
		wr(OFS_INT_CLEAR, 32'hf);
		wr(OFS_INT_ENABLE, 32'h0);
		f0 = fr;
		power_down <= 1'b1;
		timeout(3'h0, 200, 256, 4'h2);
		chk(fr, f0);
		rd(OFS_STATE, 32'h3);
		rd(OFS_INT_STATUS, 32'h2);
		chk(irq, 1'b0);
		wr(OFS_INT_ENABLE, 32'h2);
		repeat (3) @(posedge clk_sys);
		chk(irq, 1'b1);
		wr(OFS_INT_CLEAR, 32'h2);
		repeat (3) @(posedge clk_sys);
		chk(irq, 1'b0);
		power_down <= 1'b0;
		pulse(4'h1);
		chk(expiry, 1'b0);
		wr(OFS_CONTROL, 32'h0);
		wait_reset(f0);
		rd(OFS_CAUSE, 32'h1);
		rd(OFS_CONTROL, 32'h53);
		rd(OFS_INT_STATUS, 32'h4);
		wr(OFS_CAUSE, 32'h0);
		rd(OFS_CAUSE, 32'h0);
		wr(OFS_GUARD, 32'haa);
		repeat (DLY + 20) @(posedge clk_sys);
		chk(fr, f0 + 1);
		rd(OFS_GUARD, 32'haa);
		wr(OFS_GUARD, 32'h12);
		wait_reset(f0 + 1);
		rd(OFS_CAUSE, 32'h8);
		rd(OFS_GUARD, 32'h55);
		summarize;
	end
endmodule // tb
